// File: common/bcc_pkg.sv
// package for the word conversion and signed compare datapath
// assumes a single 20 MHz clock and an APB3 master on the register side
`default_nettype none
package bcc_pkg;
    // ************************************
    // register offsets (byte addresses)
    // ************************************
    localparam logic [7:0] BCC_OFF_CTRL = 8'h00;
    localparam logic [7:0] BCC_OFF_GO = 8'h04;
    localparam logic [7:0] BCC_OFF_OPA = 8'h08;
    localparam logic [7:0] BCC_OFF_OPB = 8'h0C;
    localparam logic [7:0] BCC_OFF_RES = 8'h10;
    localparam logic [7:0] BCC_OFF_STAT = 8'h14;
    // ************************************
    // field positions
    // ************************************
    localparam int BCC_CTRL_EXEC = 0;
    localparam int BCC_CTRL_OP_LSB = 4;
    localparam int BCC_CTRL_PTR = 8;
    localparam int BCC_CTRL_AREA = 9;
    localparam int BCC_ST_ABOVE = 0;
    localparam int BCC_ST_MATCH = 1;
    localparam int BCC_ST_BELOW = 2;
    localparam int BCC_ST_FAULT = 3;
    localparam int BCC_ST_ZERO = 4;
    localparam int BCC_ST_POL = 5;
    localparam int BCC_ST_BUSY = 8;
    // ************************************
    // operation codes
    // ************************************
    localparam logic [2:0] BCC_OP_CMP = 3'h0;
    localparam logic [2:0] BCC_OP_D2H_W = 3'h1;
    localparam logic [2:0] BCC_OP_D2H_D = 3'h2;
    localparam logic [2:0] BCC_OP_H2D_W = 3'h3;
    localparam logic [2:0] BCC_OP_H2D_D = 3'h4;
    localparam logic [2:0] BCC_OP_TIME = 3'h5;
    // ************************************
    // limits, counts and reset values
    // ************************************
    localparam logic [15:0] BCC_HEX_WORD_MAX = 16'h270F;
    localparam logic [31:0] BCC_HEX_DBL_MAX = 32'h05F5E0FF;
    localparam logic [7:0] BCC_TIME_FIELD_MAX = 8'h59;
    localparam logic [31:0] BCC_SEC_PER_HOUR = 32'h00000E10;
    localparam logic [5:0] BCC_DIG_WORD = 6'h04;
    localparam logic [5:0] BCC_DIG_DBL = 6'h08;
    localparam logic [5:0] BCC_BITS_WORD = 6'h10;
    localparam logic [5:0] BCC_BITS_DBL = 6'h20;
    localparam logic [31:0] BCC_RST_WORD = 32'h00000000;
    typedef enum logic [1:0] {
        BCC_IDLE = 2'b00,
        BCC_TO_BIN = 2'b01,
        BCC_TO_BCD = 2'b10
    } bcc_state_e;
endpackage
`default_nettype wire

// File: verilog/bcc_core.sv
// apb slave holding the signed double compare and bcd/binary/time conversions
// assumes a synchronous apb3 master on clk_i; no other clock, no interrupt
//
// Overview of operation
// - compare reads each operand as one signed 32-bit value, high word on top
// - compare leaves exactly one of above, match and below flags set
// - with the execution condition off nothing runs and nothing changes
// - conversions write only the result words, sources stay untouched
// - word decimal-to-hex turns four bcd digits into the equal binary
// - word decimal-to-hex with a bad digit sets fault and writes nothing
// - each conversion sets zero when its result is zero, clears otherwise
// - bcd-to-binary conversions always clear the polarity flag
// - double decimal-to-hex turns eight bcd digits into 32-bit binary
// - word hex-to-decimal turns binary into equal bcd digits
// - word hex-to-decimal above 270F sets fault and skips the write
// - double hex-to-decimal above 05F5E0FF does not run, results kept
// - double hex-to-decimal turns a 32-bit value into eight bcd digits
// - time source: seconds in bits 7:0, minutes 15:8, hours next word
// - total seconds written as eight bcd digits over two result words
// - minutes or seconds above 59 sets fault
// - a non-bcd digit in either time source word sets fault
// - a bad indirect pointer sets fault for every operation
// - a time source or result pair crossing an area sets fault
`default_nettype none
module bcc_core
    import bcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // flags toward the sequencer
    output logic above_flag_o,
    output logic match_flag_o,
    output logic below_flag_o,
    output logic fault_flag_o,
    output logic zero_flag_o
);
    // ************************************
    // parameter check
    // ************************************
    if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
        $error("bcc_core: ADDR_W must lie between 5 and 8");
    end

    // ************************************
    // state and helpers
    // ************************************
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic exec_en;
        logic [2:0] opcode;
        logic ptr_fault;
        logic area_fault;
        logic [31:0] opa;
        logic [31:0] opb;
        logic [31:0] res;
        logic above;
        logic match;
        logic below;
        logic fault;
        logic zero;
        logic polarity;
        bcc_state_e state;
        logic [2:0] op_run;
        logic [5:0] cnt;
        logic [31:0] acc;
        logic [31:0] sh;
        logic [31:0] bcd;
        logic [15:0] msec;
        logic [31:0] src_cp;
        logic done;
    } bcc_reg_s;

    bcc_reg_s q;
    bcc_reg_s d;
    logic [7:0] addr;
    logic rd_hit;
    logic [31:0] rd_val;
    logic wr_fire;
    logic go;

    // nibbles in the low n digits must all be 0..9
    function automatic logic bcd_ok(input logic [31:0] v, input logic [5:0] n);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (6'(i) < n && v[4*i +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // add three to every digit of five or more before the shift
    function automatic logic [31:0] dd_adjust(input logic [31:0] b);
        logic [31:0] r;
        r = b;
        for (int i = 0; i < 8; i++) begin
            if (b[4*i +: 4] > 4'h4) begin
                r[4*i +: 4] = b[4*i +: 4] + 4'h3;
            end
        end
        return r;
    endfunction

    // reference decode of a valid bcd word, only the checks read it
    function automatic logic [31:0] bcd_ref(input logic [31:0] v);
        logic [31:0] a;
        a = BCC_RST_WORD;
        for (int i = 7; i >= 0; i--) begin
            a = 32'(a * 32'd10) + {28'h0, v[4*i +: 4]};
        end
        return a;
    endfunction

    assign addr = 8'(paddr_i);
    assign wr_fire = psel_i && penable_i && q.pready && pwrite_i && !q.pslverr;
    assign go = wr_fire && addr == BCC_OFF_GO;

    // ************************************
    // read decode
    // ************************************
    always_comb begin
        rd_hit = 1'b1;
        rd_val = BCC_RST_WORD;
        unique case (addr)
            BCC_OFF_CTRL: begin
                rd_val[BCC_CTRL_EXEC] = q.exec_en;
                rd_val[BCC_CTRL_OP_LSB +: 3] = q.opcode;
                rd_val[BCC_CTRL_PTR] = q.ptr_fault;
                rd_val[BCC_CTRL_AREA] = q.area_fault;
            end
            BCC_OFF_GO: rd_val = BCC_RST_WORD;
            BCC_OFF_OPA: rd_val = q.opa;
            BCC_OFF_OPB: rd_val = q.opb;
            BCC_OFF_RES: rd_val = q.res;
            BCC_OFF_STAT: begin
                rd_val[BCC_ST_ABOVE] = q.above;
                rd_val[BCC_ST_MATCH] = q.match;
                rd_val[BCC_ST_BELOW] = q.below;
                rd_val[BCC_ST_FAULT] = q.fault;
                rd_val[BCC_ST_ZERO] = q.zero;
                rd_val[BCC_ST_POL] = q.polarity;
                rd_val[BCC_ST_BUSY] = q.state != BCC_IDLE;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // ************************************
    // next state
    // ************************************
    always_comb begin
        logic [31:0] acc_n;
        logic [31:0] bcd_n;
        logic [6:0] mins;
        logic [6:0] secs;
        logic [31:0] adj;
        acc_n = BCC_RST_WORD;
        bcd_n = BCC_RST_WORD;
        adj = BCC_RST_WORD;
        mins = 7'(q.opa[15:12] * 4'hA) + {3'h0, q.opa[11:8]};
        secs = 7'(q.opa[7:4] * 4'hA) + {3'h0, q.opa[3:0]};
        d = q;
        d.done = 1'b0;
        // one wait state: answer prepared in the first access cycle
        if (psel_i && penable_i && !q.pready) begin
            d.pready = 1'b1;
            d.pslverr = !rd_hit;
            d.prdata = pwrite_i ? BCC_RST_WORD : rd_val;
        end else begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
            d.prdata = BCC_RST_WORD;
        end
        // operand writes never come from the engine, so sources stay put
        if (wr_fire) begin
            unique case (addr)
                BCC_OFF_CTRL: begin
                    d.exec_en = pwdata_i[BCC_CTRL_EXEC];
                    d.opcode = pwdata_i[BCC_CTRL_OP_LSB +: 3];
                    d.ptr_fault = pwdata_i[BCC_CTRL_PTR];
                    d.area_fault = pwdata_i[BCC_CTRL_AREA];
                end
                BCC_OFF_OPA: d.opa = pwdata_i;
                BCC_OFF_OPB: d.opb = pwdata_i;
                default: ;
            endcase
        end
        // start: ignored while busy or with the condition off
        if (go && q.exec_en && q.state == BCC_IDLE) begin
            d.fault = 1'b0;
            d.op_run = q.opcode;
            d.acc = BCC_RST_WORD;
            d.bcd = BCC_RST_WORD;
            d.src_cp = q.opa;
            if (q.ptr_fault) begin
                d.fault = 1'b1;
            end else begin
                unique case (q.opcode)
                    BCC_OP_CMP: begin
                        d.above = $signed(q.opa) > $signed(q.opb);
                        d.match = q.opa == q.opb;
                        d.below = $signed(q.opa) < $signed(q.opb);
                    end
                    BCC_OP_D2H_W: begin
                        if (!bcd_ok(q.opa, BCC_DIG_WORD)) begin
                            d.fault = 1'b1;
                        end else begin
                            d.sh = {q.opa[15:0], 16'h0000};
                            d.cnt = BCC_DIG_WORD;
                            d.state = BCC_TO_BIN;
                        end
                    end
                    BCC_OP_D2H_D: begin
                        if (!bcd_ok(q.opa, BCC_DIG_DBL)) begin
                            d.fault = 1'b1;
                        end else begin
                            d.sh = q.opa;
                            d.cnt = BCC_DIG_DBL;
                            d.state = BCC_TO_BIN;
                        end
                    end
                    BCC_OP_H2D_W: begin
                        if (q.opa[15:0] > BCC_HEX_WORD_MAX) begin
                            d.fault = 1'b1;
                        end else begin
                            d.sh = {q.opa[15:0], 16'h0000};
                            d.cnt = BCC_BITS_WORD;
                            d.state = BCC_TO_BCD;
                        end
                    end
                    BCC_OP_H2D_D: begin
                        if (q.opa > BCC_HEX_DBL_MAX) begin
                            d.fault = 1'b1;
                        end else begin
                            d.sh = q.opa;
                            d.cnt = BCC_BITS_DBL;
                            d.state = BCC_TO_BCD;
                        end
                    end
                    BCC_OP_TIME: begin
                        if (q.area_fault) begin
                            d.fault = 1'b1;
                        end else if (!bcd_ok(q.opa, BCC_DIG_DBL)) begin
                            d.fault = 1'b1;
                        end else if (q.opa[15:8] > BCC_TIME_FIELD_MAX || q.opa[7:0] > BCC_TIME_FIELD_MAX) begin
                            d.fault = 1'b1;
                        end else begin
                            // minutes and seconds folded now, hours decoded below
                            d.msec = 16'(mins * 7'd60) + {9'h000, secs};
                            d.sh = {q.opa[31:16], 16'h0000};
                            d.cnt = BCC_DIG_WORD;
                            d.state = BCC_TO_BIN;
                        end
                    end
                    default: d.fault = 1'b1;
                endcase
            end
        end
        // iterative engine, one digit or one bit per cycle
        unique case (q.state)
            BCC_IDLE: ;
            BCC_TO_BIN: begin
                acc_n = 32'(q.acc * 32'd10) + {28'h0, q.sh[31:28]};
                d.acc = acc_n;
                d.sh = {q.sh[27:0], 4'h0};
                d.cnt = q.cnt - 6'h01;
                if (q.cnt == 6'h01) begin
                    if (q.op_run == BCC_OP_TIME) begin
                        // hours max 9999 keeps the total inside 32 bits
                        d.sh = 32'(acc_n * BCC_SEC_PER_HOUR) + {16'h0000, q.msec};
                        d.bcd = BCC_RST_WORD;
                        d.cnt = BCC_BITS_DBL;
                        d.state = BCC_TO_BCD;
                    end else begin
                        if (q.op_run == BCC_OP_D2H_W) begin
                            d.res[15:0] = acc_n[15:0];
                        end else begin
                            d.res = acc_n;
                        end
                        d.zero = acc_n == BCC_RST_WORD;
                        d.polarity = 1'b0;
                        d.done = 1'b1;
                        d.state = BCC_IDLE;
                    end
                end
            end
            BCC_TO_BCD: begin
                adj = dd_adjust(q.bcd);
                bcd_n = {adj[30:0], q.sh[31]};
                d.bcd = bcd_n;
                d.sh = {q.sh[30:0], 1'b0};
                d.cnt = q.cnt - 6'h01;
                if (q.cnt == 6'h01) begin
                    if (q.op_run == BCC_OP_H2D_W) begin
                        d.res[15:0] = bcd_n[15:0];
                        d.zero = bcd_n[15:0] == 16'h0000;
                    end else begin
                        d.res = bcd_n;
                        d.zero = bcd_n == BCC_RST_WORD;
                    end
                    d.done = 1'b1;
                    d.state = BCC_IDLE;
                end
            end
            default: d.state = BCC_IDLE;
        endcase
    end

    // ************************************
    // registers
    // ************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign above_flag_o = q.above;
    assign match_flag_o = q.match;
    assign below_flag_o = q.below;
    assign fault_flag_o = q.fault;
    assign zero_flag_o = q.zero;

    // ************************************
    // checks
    // ************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_cmp_signed_order: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && q.opcode == BCC_OP_CMP
        |=> above_flag_o == ($signed($past(q.opa)) > $signed($past(q.opb))))
        else $error("signed compare gave wrong above flag");
    a_cmp_one_flag: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && q.opcode == BCC_OP_CMP
        |=> $onehot({above_flag_o, match_flag_o, below_flag_o}))
        else $error("compare did not leave exactly one flag");
    a_off_no_change: assert property (
        go && !q.exec_en && q.state == BCC_IDLE
        |=> $stable(q.res) && $stable({q.above, q.match, q.below, q.fault, q.zero}) && q.state == BCC_IDLE)
        else $error("operation ran with condition off");
    a_word_bin_value: assert property (
        q.done && q.op_run == BCC_OP_D2H_W |-> q.res[15:0] == 16'(bcd_ref({16'h0000, q.src_cp[15:0]})))
        else $error("word decimal to hex value wrong");
    a_bad_digit_fault: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && q.opcode == BCC_OP_D2H_W
        && !bcd_ok(q.opa, BCC_DIG_WORD) |=> fault_flag_o && $stable(q.res) ##1 $stable(q.res))
        else $error("bad digit not refused");
    a_zero_follows: assert property (
        q.done && q.op_run != BCC_OP_D2H_W && q.op_run != BCC_OP_H2D_W |-> zero_flag_o == (q.res == 32'h00000000))
        else $error("zero flag disagrees with result");
    a_polarity_clear: assert property (
        q.done && (q.op_run == BCC_OP_D2H_W || q.op_run == BCC_OP_D2H_D) |-> !q.polarity)
        else $error("polarity set after bcd to binary");
    a_word_hex_limit: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && q.opcode == BCC_OP_H2D_W
        && q.opa[15:0] > BCC_HEX_WORD_MAX |=> fault_flag_o && q.state == BCC_IDLE)
        else $error("word hex limit not enforced");
    a_dbl_hex_limit: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && q.opcode == BCC_OP_H2D_D
        && q.opa > BCC_HEX_DBL_MAX |=> $stable(q.res) [*3])
        else $error("double hex limit not enforced");
    a_dbl_hex_value: assert property (
        q.done && q.op_run == BCC_OP_H2D_D |-> bcd_ref(q.res) == q.src_cp)
        else $error("double hex to decimal value wrong");
    a_time_fields: assert property (
        go && q.exec_en && q.state == BCC_IDLE && !q.ptr_fault && !q.area_fault && q.opcode == BCC_OP_TIME
        && bcd_ok(q.opa, BCC_DIG_DBL) && q.opa[7:0] > BCC_TIME_FIELD_MAX |=> fault_flag_o)
        else $error("seconds above 59 not refused");
    a_ptr_fault_any: assert property (
        go && q.exec_en && q.state == BCC_IDLE && q.ptr_fault |=> fault_flag_o && $stable(q.res))
        else $error("pointer fault not flagged");
endmodule
`default_nettype wire

// File: dv/bcc_seq_model.sv
// apb master standing in for the instruction sequencer and its word memory
// assumes one rising-edge clock shared with the slave; the slave sets pready
`default_nettype none
module bcc_seq_model (
    // clock
    input wire logic clk_i,
    // apb master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
    end
    // one transfer: setup, then access held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines flip so a stale value can never pass
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
endmodule
`default_nettype wire

// File: dv/bcc_core_tb.sv
// self-checking bench for the word conversion and signed compare datapath
// assumes bcc_core with the register map of bcc_pkg and the sequencer model
`default_nettype none
module bcc_core_tb
    import bcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************
    // signals and case table
    // ****************************
    typedef struct packed {
        logic [2:0] op;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic [5:0] st;
        logic [5:0] msk;
    } bcc_row_s;
    localparam bcc_row_s ROWS [19] = '{
        '{BCC_OP_CMP, 32'hFFFFFFFF, 32'h00000001, 32'h00000000, 6'h04, 6'h07},
        '{BCC_OP_CMP, 32'h80000000, 32'h80000000, 32'h00000000, 6'h02, 6'h07},
        '{BCC_OP_CMP, 32'h00000001, 32'hFFFFFFFF, 32'h00000000, 6'h01, 6'h07},
        '{BCC_OP_CMP, 32'h00010000, 32'h0000FFFF, 32'h00000000, 6'h01, 6'h07},
        '{BCC_OP_CMP, 32'h7FFFFFFF, 32'h80000000, 32'h00000000, 6'h01, 6'h07},
        '{BCC_OP_D2H_D, 32'h12345678, 32'h0, 32'h00BC614E, 6'h00, 6'h38},
        '{BCC_OP_D2H_W, 32'h12349999, 32'h0, 32'h00BC270F, 6'h00, 6'h38},
        '{BCC_OP_D2H_W, 32'h000000A0, 32'h0, 32'h00BC270F, 6'h08, 6'h08},
        '{BCC_OP_D2H_D, 32'hA0000000, 32'h0, 32'h00BC270F, 6'h08, 6'h08},
        '{BCC_OP_H2D_W, 32'h0000270F, 32'h0, 32'h00BC9999, 6'h00, 6'h38},
        '{BCC_OP_H2D_W, 32'h00002710, 32'h0, 32'h00BC9999, 6'h08, 6'h08},
        '{BCC_OP_H2D_D, 32'h05F5E0FF, 32'h0, 32'h99999999, 6'h00, 6'h38},
        '{BCC_OP_H2D_D, 32'h05F5E100, 32'h0, 32'h99999999, 6'h08, 6'h08},
        '{BCC_OP_TIME, 32'h28153207, 32'h0, 32'h10135927, 6'h00, 6'h38},
        '{BCC_OP_TIME, 32'h00006000, 32'h0, 32'h10135927, 6'h08, 6'h08},
        '{BCC_OP_TIME, 32'h00000060, 32'h0, 32'h10135927, 6'h08, 6'h08},
        '{BCC_OP_TIME, 32'h000A0000, 32'h0, 32'h10135927, 6'h08, 6'h08},
        '{BCC_OP_D2H_D, 32'h00000000, 32'h0, 32'h00000000, 6'h10, 6'h38},
        '{3'h6, 32'h00000000, 32'h0, 32'h00000000, 6'h08, 6'h08}
    };
    logic clk;
    logic rst_b;
    logic psel, penable, pwrite, pready, pslverr, rerr;
    logic above, match, below, fault, zero;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat, st, last, pins;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    assign pins = {27'h0, zero, fault, below, match, above};
    bcc_core bcc_core_i (
        .clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .above_flag_o(above), .match_flag_o(match), .below_flag_o(below), .fault_flag_o(fault),
        .zero_flag_o(zero)
    );
    bcc_seq_model bcc_seq_model_i (
        .clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr)
    );
    // ****************************
    // clock, timeout and tasks
    // ****************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // a hung handshake ends the run instead of stalling forever
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks run %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bcc_seq_model_i.xfer(1'b1, a, d, rdat, rerr);
    endtask
    task automatic rd(input logic [7:0] a);
        bcc_seq_model_i.xfer(1'b0, a, 32'h0, rdat, rerr);
    endtask
    // load operands, start, poll busy; leaves status in st and result in rdat
    task automatic run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] b,
                          input logic [1:0] flt, input logic ex);
        wr(BCC_OFF_OPA, a);
        wr(BCC_OFF_OPB, b);
        wr(BCC_OFF_CTRL, {22'h0, flt, 1'b0, op, 3'h0, ex});
        wr(BCC_OFF_GO, 32'h00000001);
        do begin
            rd(BCC_OFF_STAT);
        end while (rdat[BCC_ST_BUSY] !== 1'b0);
        st = rdat;
        rd(BCC_OFF_RES);
    endtask
    // ****************************
    // main sequence
    // ****************************
    initial begin
        rst_b = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(BCC_OFF_STAT);
        chk("status at reset", rdat, 32'h0);
        chk("flag pins at reset", pins, 32'h0);
        rd(BCC_OFF_RES);
        chk("result at reset", rdat, 32'h0);
        $display("test reset done");
        foreach (ROWS[i]) begin
            run_op(ROWS[i].op, ROWS[i].a, ROWS[i].b, 2'b00, 1'b1);
            chk("result", rdat, ROWS[i].res);
            chk("status", st & {26'h0, ROWS[i].msk}, {26'h0, ROWS[i].st});
            chk("flag pins", pins & {26'h0, ROWS[i].msk}, {26'h0, ROWS[i].st});
            rd(BCC_OFF_OPA);
            chk("source kept", rdat, ROWS[i].a);
            $display("test row %0d done", i);
        end
        // start with the execution condition off must change nothing
        last = st;
        run_op(BCC_OP_D2H_D, 32'h00000001, 32'h0, 2'b00, 1'b0);
        chk("status exec off", st, last);
        chk("result exec off", rdat, 32'h0);
        $display("test exec off done");
        // software-supplied address faults
        run_op(BCC_OP_CMP, 32'h00000005, 32'h00000005, 2'b01, 1'b1);
        chk("pointer fault pin", {31'h0, fault}, 32'h1);
        run_op(BCC_OP_TIME, 32'h00000001, 32'h0, 2'b10, 1'b1);
        chk("area fault", st & 32'h8, 32'h8);
        chk("area result kept", rdat, 32'h0);
        $display("test address faults done");
        rd(8'h20);
        chk("unmapped error", {31'h0, rerr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        $display("test unmapped done");
        // mid-run reset must drop every flag left by the earlier tests
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(BCC_OFF_STAT);
        chk("status after reset", rdat, 32'h0);
        chk("flag pins after reset", pins, 32'h0);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
`default_nettype wire
